//--- gtu_consts.vh
// constants for the general timer unit
`ifndef GTU_CONSTS_VH
`define GTU_CONSTS_VH
`define GTU_W          16
`define GTU_ADDR_W     8
// register byte offsets
`define GTU_OFS_CTRL0  8'h00
`define GTU_OFS_CTRL1  8'h04
`define GTU_OFS_CTRL2  8'h08
`define GTU_OFS_CTRL3  8'h0c
`define GTU_OFS_CTRL4  8'h10
`define GTU_OFS_CNT0   8'h20
`define GTU_OFS_CNT1   8'h24
`define GTU_OFS_CNT2   8'h28
`define GTU_OFS_CNT3   8'h2c
`define GTU_OFS_CNT4   8'h30
`define GTU_OFS_CAPTURE_RELOAD_REG 8'h34
`define GTU_OFS_STAT   8'h38
// control field layout
`define GTU_F_RUN      0
`define GTU_F_MODE_LO  1
`define GTU_F_MODE_HI  3
`define GTU_F_DIRSW    4
`define GTU_F_DIREXT   5
`define GTU_F_PRE_LO   6
`define GTU_F_PRE_HI   8
`define GTU_F_EDGE_LO  9
`define GTU_F_EDGE_HI  10
`define GTU_F_OUTEN    11
`define GTU_F_CLRCAP   12
`define GTU_F_CAPSRC_LO 13
`define GTU_F_CAPSRC_HI 14
`define GTU_CTRL_W     15
`define GTU_CTRL_RST   15'h0000
// modes
`define GTU_M_TIMER    3'h0
`define GTU_M_COUNTER  3'h1
`define GTU_M_GATE_LO  3'h2
`define GTU_M_GATE_HI  3'h3
`define GTU_M_ENCODER  3'h4
`define GTU_M_CHAIN    3'h5
`define GTU_M_RELOAD   3'h6
`define GTU_M_CAPTURE  3'h7
// edge select
`define GTU_E_RISE     2'h1
`define GTU_E_FALL     2'h2
`define GTU_E_BOTH     2'h3
// base tick divisors
`define GTU_G1_BASE    4
`define GTU_G2_BASE    2
`define GTU_PRE_W      10
`endif

//--- gtu_timer_unit.v
// general timer unit with two timer groups and an apb register port
`timescale 1ns/1ps
`include "gtu_consts.vh"
module gtu_timer_unit (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [4:0]  timer_input_pin,
   input  wire [4:0]  timer_direction_pin,
   input  wire        capture_trigger_pin,
   output wire        core_toggle_out_pin,
   output wire        group_two_toggle_out_pin,
   output reg         capture_compare_timers_clk
);
   // timer index: 0 aux_timer_a, 1 core_timer, 2 aux_timer_b,
   // 3 group_two_aux_timer, 4 group_two_core_timer
   localparam N = 5;
   // one loop index per process so that no variable has two drivers
   integer i;
   integer k;
   integer m;
   integer r;
   reg  [`GTU_CTRL_W-1:0] ctrl_reg [0:N-1];
   reg  [`GTU_W-1:0]      cnt_reg  [0:N-1];
   reg  [`GTU_W-1:0]      capture_reload_reg;
   reg                    core_toggle_latch;
   reg                    group_two_toggle_latch;
   reg  [4:0]             in_s1_reg, in_s2_reg, in_s3_reg;
   reg  [4:0]             dir_s1_reg, dir_s2_reg, dir_s3_reg;
   reg  [2:0]             cap_s_reg;
   reg  [`GTU_PRE_W-1:0]  g1_div_reg;
   reg  [`GTU_PRE_W-1:0]  g2_div_reg;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, third stage only for edge detection
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_s1_reg  <= 5'h00;
         in_s2_reg  <= 5'h00;
         in_s3_reg  <= 5'h00;
         dir_s1_reg <= 5'h00;
         dir_s2_reg <= 5'h00;
         dir_s3_reg <= 5'h00;
         cap_s_reg  <= 3'h0;
      end else begin
         in_s1_reg  <= timer_input_pin;
         in_s2_reg  <= in_s1_reg;
         in_s3_reg  <= in_s2_reg;
         dir_s1_reg <= timer_direction_pin;
         dir_s2_reg <= dir_s1_reg;
         dir_s3_reg <= dir_s2_reg;
         cap_s_reg  <= {cap_s_reg[1:0], capture_trigger_pin};
      end
   end

   wire [4:0] in_rise  = in_s2_reg & ~in_s3_reg;
   wire [4:0] in_fall  = ~in_s2_reg & in_s3_reg;
   wire [4:0] dir_any  = dir_s2_reg ^ dir_s3_reg;
   wire       cap_rise = cap_s_reg[1] & ~cap_s_reg[2];
   wire       cap_fall = ~cap_s_reg[1] & cap_s_reg[2];

   ////////////////////////////////////////////////////////////////////////
   // free-running prescaler dividers, one per group
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g1_div_reg <= {`GTU_PRE_W{1'b0}};
         g2_div_reg <= {`GTU_PRE_W{1'b0}};
      end else begin
         g1_div_reg <= g1_div_reg + 1'b1;
         g2_div_reg <= g2_div_reg + 1'b1;
      end
   end

   // base steps: group one every 4 clocks, group two every 2
   wire [31:0]           g1_base_full = `GTU_G1_BASE - 1;
   wire [31:0]           g2_base_full = `GTU_G2_BASE - 1;
   wire [`GTU_PRE_W-1:0] g1_base      = g1_base_full[`GTU_PRE_W-1:0];
   wire [`GTU_PRE_W-1:0] g2_base      = g2_base_full[`GTU_PRE_W-1:0];

   // prescaled tick for timer k: base divisor times 2**pre
   function tick_of;
      input [`GTU_PRE_W-1:0] div;
      input [2:0]            pre;
      input                  g2;
      reg   [`GTU_PRE_W-1:0] m;
      begin
         m = ((g2 ? g2_base : g1_base) + 1'b1);
         m = (m << pre) - 1'b1;
         tick_of = ((div & m) == m);
      end
   endfunction

   // edge selection helper
   function edge_hit;
      input [1:0] sel;
      input       r;
      input       f;
      begin
         edge_hit = (sel[0] & r) | (sel[1] & f);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // per-timer step and direction decode
   reg [N-1:0] step;
   reg [N-1:0] up;
   reg [N-1:0] wrap;
   reg [2:0]   md;
   reg         tk;
   reg         enc_a_edge;
   always @* begin
      step = {N{1'b0}};
      up   = {N{1'b0}};
      md   = 3'h0;
      tk   = 1'b0;
      enc_a_edge = 1'b0;
      for (i = 0; i < N; i = i + 1) begin
         md = ctrl_reg[i][`GTU_F_MODE_HI:`GTU_F_MODE_LO];
         tk = (i < 3) ? tick_of(g1_div_reg, ctrl_reg[i][`GTU_F_PRE_HI:`GTU_F_PRE_LO], 1'b0)
                      : tick_of(g2_div_reg, ctrl_reg[i][`GTU_F_PRE_HI:`GTU_F_PRE_LO], 1'b1);
         // direction from software or the direction pin
         up[i] = ctrl_reg[i][`GTU_F_DIREXT] ? ~(dir_s2_reg[i] ^ ctrl_reg[i][`GTU_F_DIRSW])
                                          : ~ctrl_reg[i][`GTU_F_DIRSW];
         case (md)
            `GTU_M_TIMER:   step[i] = tk;
            `GTU_M_COUNTER: step[i] = edge_hit(ctrl_reg[i][`GTU_F_EDGE_HI:`GTU_F_EDGE_LO],
                                               in_rise[i], in_fall[i]);
            `GTU_M_GATE_LO: step[i] = tk & ~in_s2_reg[i];
            `GTU_M_GATE_HI: step[i] = tk & in_s2_reg[i];
            `GTU_M_ENCODER: begin
               // quadrature on group-one timers only: any edge on a or b steps, phase gives direction
               enc_a_edge = in_rise[i] | in_fall[i];
               step[i] = (i < 3) & (enc_a_edge | dir_any[i]);
               up[i] = enc_a_edge ? (in_s2_reg[i] != dir_s2_reg[i])
                                  : (in_s2_reg[i] == dir_s2_reg[i]);
            end
            default: step[i] = 1'b0; // chain handled below; capture/reload stopped
         endcase
      end
   end

   // final step and direction after chaining and run gating
   reg [N-1:0] step_f;
   reg [N-1:0] up_f;

   // wrap detection per timer
   always @* begin
      for (k = 0; k < N; k = k + 1)
         wrap[k] = step_f[k] & (up_f[k] ? (cnt_reg[k] == {`GTU_W{1'b1}})
                                        : (cnt_reg[k] == {`GTU_W{1'b0}}));
   end

   ////////////////////////////////////////////////////////////////////////
   // chaining: aux timers clocked by the toggle latch transitions
   wire core_tl_rise = wrap[1] & ~core_toggle_latch;
   wire core_tl_fall = wrap[1] & core_toggle_latch;
   wire g2_tl_any    = wrap[4];
   always @* begin
      step_f = step;
      up_f   = up;
      for (m = 0; m < N; m = m + 1) begin
         if (ctrl_reg[m][`GTU_F_MODE_HI:`GTU_F_MODE_LO] == `GTU_M_CHAIN) begin
            if (m == 0 || m == 2)
               step_f[m] = edge_hit(ctrl_reg[m][`GTU_F_EDGE_HI:`GTU_F_EDGE_LO],
                                    core_tl_rise, core_tl_fall);
            else if (m == 3)
               step_f[m] = g2_tl_any;
         end
         if (ctrl_reg[m][`GTU_F_RUN] == 1'b0)
            step_f[m] = 1'b0;
      end
   end

   // core toggle latch transition used as trigger by either aux timer
   function reload_hit;
      input [`GTU_CTRL_W-1:0] c;
      input                   pr;
      input                   pf;
      input                   tr;
      input                   tf;
      begin
         reload_hit = (c[`GTU_F_MODE_HI:`GTU_F_MODE_LO] == `GTU_M_RELOAD) &
                      (c[`GTU_F_CAPSRC_LO] ? edge_hit(c[`GTU_F_EDGE_HI:`GTU_F_EDGE_LO], tr, tf)
                                           : edge_hit(c[`GTU_F_EDGE_HI:`GTU_F_EDGE_LO], pr, pf));
      end
   endfunction

   wire rel_a = reload_hit(ctrl_reg[0], in_rise[0], in_fall[0],
                           core_tl_rise, core_tl_fall);
   wire rel_b = reload_hit(ctrl_reg[2], in_rise[2], in_fall[2],
                           core_tl_rise, core_tl_fall);
   wire cap_a = (ctrl_reg[0][`GTU_F_MODE_HI:`GTU_F_MODE_LO] == `GTU_M_CAPTURE) &
                edge_hit(ctrl_reg[0][`GTU_F_EDGE_HI:`GTU_F_EDGE_LO], in_rise[0], in_fall[0]);
   wire cap_b = (ctrl_reg[2][`GTU_F_MODE_HI:`GTU_F_MODE_LO] == `GTU_M_CAPTURE) &
                edge_hit(ctrl_reg[2][`GTU_F_EDGE_HI:`GTU_F_EDGE_LO], in_rise[2], in_fall[2]);

   // group-two capture trigger source select
   wire [1:0] csrc = ctrl_reg[3][`GTU_F_CAPSRC_HI:`GTU_F_CAPSRC_LO];
   wire [1:0] cedg = ctrl_reg[4][`GTU_F_EDGE_HI:`GTU_F_EDGE_LO];
   wire g2_cap = (csrc == 2'h0) ? edge_hit(cedg, cap_rise, cap_fall)
               : ((csrc[0] & (in_rise[1] | in_fall[1])) |
                  (csrc[1] & dir_any[1]));
   // group-two core reload from the capture reload register on its wrap
   wire g2_rel = wrap[4] & ctrl_reg[4][`GTU_F_CLRCAP];

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   wire wr_en = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // counters, latches and software writes; hardware events win over writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (r = 0; r < N; r = r + 1) begin
            ctrl_reg[r] <= `GTU_CTRL_RST;
            cnt_reg[r]  <= {`GTU_W{1'b0}};
         end
         capture_reload_reg     <= {`GTU_W{1'b0}};
         core_toggle_latch      <= 1'b0;
         group_two_toggle_latch <= 1'b0;
         capture_compare_timers_clk <= 1'b0;
      end else begin
         // software writes first so that hardware updates below override
         if (wr_en) begin
            case (paddr)
               `GTU_OFS_CTRL0:  ctrl_reg[0] <= pwdata[`GTU_CTRL_W-1:0];
               `GTU_OFS_CTRL1:  ctrl_reg[1] <= pwdata[`GTU_CTRL_W-1:0];
               `GTU_OFS_CTRL2:  ctrl_reg[2] <= pwdata[`GTU_CTRL_W-1:0];
               `GTU_OFS_CTRL3:  ctrl_reg[3] <= pwdata[`GTU_CTRL_W-1:0];
               `GTU_OFS_CTRL4:  ctrl_reg[4] <= pwdata[`GTU_CTRL_W-1:0];
               `GTU_OFS_CNT0:   cnt_reg[0]  <= pwdata[`GTU_W-1:0];
               `GTU_OFS_CNT1:   cnt_reg[1]  <= pwdata[`GTU_W-1:0];
               `GTU_OFS_CNT2:   cnt_reg[2]  <= pwdata[`GTU_W-1:0];
               `GTU_OFS_CNT3:   cnt_reg[3]  <= pwdata[`GTU_W-1:0];
               `GTU_OFS_CNT4:   cnt_reg[4]  <= pwdata[`GTU_W-1:0];
               `GTU_OFS_CAPTURE_RELOAD_REG: capture_reload_reg <= pwdata[`GTU_W-1:0];
               default: ;
            endcase
         end
         // counting for all five timers
         for (r = 0; r < N; r = r + 1)
            if (step_f[r])
               cnt_reg[r] <= up_f[r] ? cnt_reg[r] + 1'b1 : cnt_reg[r] - 1'b1;
         // core toggle latch and pin
         if (wrap[1])
            core_toggle_latch <= ~core_toggle_latch;
         // reload of core from aux timers, aux stays stopped
         if (rel_a)
            cnt_reg[1] <= cnt_reg[0];
         else if (rel_b)
            cnt_reg[1] <= cnt_reg[2];
         // capture of core into aux timers
         if (cap_a)
            cnt_reg[0] <= cnt_reg[1];
         if (cap_b)
            cnt_reg[2] <= cnt_reg[1];
         // group-two toggle latch, capture-compare clock pulse
         if (wrap[4])
            group_two_toggle_latch <= ~group_two_toggle_latch;
         capture_compare_timers_clk <= wrap[4];
         if (g2_rel)
            cnt_reg[4] <= capture_reload_reg;
         // capture group-two aux into capture reload register
         if (g2_cap) begin
            capture_reload_reg <= cnt_reg[3];
            if (ctrl_reg[3][`GTU_F_CLRCAP])
               cnt_reg[3] <= {`GTU_W{1'b0}};
         end
      end
   end

   assign core_toggle_out_pin      = core_toggle_latch & ctrl_reg[1][`GTU_F_OUTEN];
   assign group_two_toggle_out_pin = group_two_toggle_latch & ctrl_reg[4][`GTU_F_OUTEN];

   ////////////////////////////////////////////////////////////////////////
   // apb read mux, unmapped reads zero
   always @* begin
      case (paddr)
         `GTU_OFS_CTRL0:  prdata = {17'h00000, ctrl_reg[0]};
         `GTU_OFS_CTRL1:  prdata = {17'h00000, ctrl_reg[1]};
         `GTU_OFS_CTRL2:  prdata = {17'h00000, ctrl_reg[2]};
         `GTU_OFS_CTRL3:  prdata = {17'h00000, ctrl_reg[3]};
         `GTU_OFS_CTRL4:  prdata = {17'h00000, ctrl_reg[4]};
         `GTU_OFS_CNT0:   prdata = {16'h0000, cnt_reg[0]};
         `GTU_OFS_CNT1:   prdata = {16'h0000, cnt_reg[1]};
         `GTU_OFS_CNT2:   prdata = {16'h0000, cnt_reg[2]};
         `GTU_OFS_CNT3:   prdata = {16'h0000, cnt_reg[3]};
         `GTU_OFS_CNT4:   prdata = {16'h0000, cnt_reg[4]};
         `GTU_OFS_CAPTURE_RELOAD_REG: prdata = {16'h0000, capture_reload_reg};
         `GTU_OFS_STAT:   prdata = {30'h00000000, group_two_toggle_latch, core_toggle_latch};
         default:         prdata = 32'h00000000;
      endcase
   end
endmodule

//--- gtu_timer_properties.sv
// assertion checker for the timer unit register port and toggle pins
`timescale 1ns/1ps
`include "gtu_consts.vh"
module gtu_timer_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        core_toggle_out_pin,
   input wire logic        group_two_toggle_out_pin,
   input wire logic        capture_compare_timers_clk
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic oe1_reg;
   logic oe4_reg;
   wire  wr_now = psel && penable && pwrite;
   wire  rd_stat = psel && !pwrite && paddr == `GTU_OFS_STAT;
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the two output enable bits, taken from completed writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe1_reg <= 1'b0;
         oe4_reg <= 1'b0;
      end else if (wr_now && paddr == `GTU_OFS_CTRL1) begin
         oe1_reg <= pwdata[`GTU_F_OUTEN];
      end else if (wr_now && paddr == `GTU_OFS_CTRL4) begin
         oe4_reg <= pwdata[`GTU_F_OUTEN];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_always: assert property (psel |-> pready)
      else $error("pready low in a transfer");
   a_no_error: assert property (psel && penable |-> !pslverr)
      else $error("pslverr raised");
   a_unmapped_zero: assert property (psel && !pwrite && paddr == 8'h3c |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_reset_idle: assert property ($rose(presetn) |->
      !core_toggle_out_pin && !group_two_toggle_out_pin && !capture_compare_timers_clk)
      else $error("outputs busy after reset");
   a_core_out_gated: assert property (core_toggle_out_pin |-> oe1_reg)
      else $error("core toggle pin high while disabled");
   a_g2_out_gated: assert property (group_two_toggle_out_pin |-> oe4_reg)
      else $error("group two toggle pin high while disabled");
   a_stat_core: assert property (rd_stat && oe1_reg |-> prdata[0] == core_toggle_out_pin)
      else $error("status bit 0 differs from core pin");
   a_stat_g2: assert property (rd_stat && oe4_reg |-> prdata[1] == group_two_toggle_out_pin)
      else $error("status bit 1 differs from group two pin");
   a_cc_single: assert property (capture_compare_timers_clk |=> !capture_compare_timers_clk)
      else $error("wrap clock pulse longer than one cycle");
   a_cc_after_wrap: assert property (capture_compare_timers_clk && oe4_reg && $past(oe4_reg, 2)
      |-> $past(group_two_toggle_out_pin) != $past(group_two_toggle_out_pin, 2)
      || group_two_toggle_out_pin != $past(group_two_toggle_out_pin))
      else $error("wrap clock pulse without a latch flip");
endmodule
bind gtu_timer_unit gtu_timer_chk gtu_timer_chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .core_toggle_out_pin,
   .group_two_toggle_out_pin, .capture_compare_timers_clk);

//--- gtu_pin_src.sv
// model of the external pulse sources and level sources on the timer pins
`timescale 1ns/1ps
module gtu_pin_src (
   input  wire logic       pclk,
   input  wire logic       go,
   input  wire logic [2:0] sel,
   input  wire logic [3:0] num,
   input  wire logic [4:0] dir_lvl,
   output logic            busy,
   output logic [4:0]      timer_input_pin,
   output logic [4:0]      timer_direction_pin,
   output logic            capture_trigger_pin
);
   logic [7:0] cnt_reg = 8'h00;
   logic [2:0] line_reg = 3'h0;
   ////////////////////////////////////////////////////////////////////////////////
   // pulses are four clocks high, four low, slow enough for the pin synchroniser
   always @(posedge pclk) begin
      if (go) begin
         cnt_reg  <= {1'b0, num, 3'h0};
         line_reg <= sel;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
   // lines 0 to 4 are timer inputs, line 5 is the capture trigger
   assign busy = go || (cnt_reg != 8'h00);
   assign timer_input_pin = (cnt_reg[2] && line_reg < 3'h5) ? (5'h01 << line_reg) : 5'h00;
   assign capture_trigger_pin = cnt_reg[2] && (line_reg == 3'h5);
   assign timer_direction_pin = dir_lvl;
endmodule

//--- tb_gtu_timer_unit.sv
// self-checking bench for the general timer unit
`timescale 1ns/1ps
`include "gtu_consts.vh"
module tb_gtu_timer_unit;
   logic        pclk, presetn, psel, penable, pwrite, go;
   logic [7:0]  paddr;
   logic [31:0] pwdata, a, b;
   logic [2:0]  sel;
   logic [3:0]  num;
   logic [4:0]  dir_lvl;
   wire  [31:0] prdata;
   wire  [4:0]  timer_input_pin, timer_direction_pin;
   wire         pready, pslverr, capture_trigger_pin, busy;
   wire         core_toggle_out_pin, group_two_toggle_out_pin, capture_compare_timers_clk;
   int          num_errors, samples_checked;
   // control offset, count offset, control word, count change over 40 clocks
   localparam logic [47:0] rows [0:8] = '{
      {8'h04, 8'h24, 16'h0001, 16'h000a},
      {8'h04, 8'h24, 16'h0041, 16'h0005},
      {8'h04, 8'h24, 16'h0011, 16'hfff6},
      {8'h08, 8'h28, 16'h0021, 16'hfff6},
      {8'h10, 8'h30, 16'h0001, 16'h0014},
      {8'h0c, 8'h2c, 16'h0021, 16'hffec},
      {8'h04, 8'h24, 16'h0005, 16'h000a},
      {8'h04, 8'h24, 16'h0007, 16'h0000},
      {8'h00, 8'h20, 16'h0009, 16'h0000}};
   gtu_timer_unit gtu_timer_unit_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .timer_input_pin, .timer_direction_pin, .capture_trigger_pin,
      .core_toggle_out_pin, .group_two_toggle_out_pin, .capture_compare_timers_clk);
   gtu_pin_src gtu_pin_src_i (.pclk, .go, .sel, .num, .dir_lvl, .busy, .timer_input_pin,
      .timer_direction_pin, .capture_trigger_pin);
   ////////////////////////////////////////////////////////////////////////////////
   // one apb transfer, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // pulses on one pin, then time for the pin stages to settle
   task automatic pulse(input logic [2:0] s, input logic [3:0] k);
      go  <= 1'b1;
      sel <= s;
      num <= k;
      @(posedge pclk);
      go <= 1'b0;
      while (busy) @(posedge pclk);
      repeat (6) @(posedge pclk);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, go, paddr, pwdata, sel, num} = '0;
      dir_lvl = 5'h0c;
      num_errors = 0;
      samples_checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 16; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0, a);
         chk("reset read", 32'h0, a);
      end
      apb(1'b1, 8'h00, 32'hffff_fffe, a);
      apb(1'b0, 8'h00, 32'h0, a);
      chk("ctrl readback", 32'h0000_7ffe, a);
      apb(1'b1, 8'h00, 32'h0, a);
      apb(1'b1, 8'h3c, 32'hffff_ffff, a);
      apb(1'b0, 8'h3c, 32'h0, a);
      chk("unmapped", 32'h0, a);
      for (int r = 0; r < 9; r++) begin
         apb(1'b1, rows[r][39:32], 32'h0, a);
         apb(1'b1, rows[r][47:40], {16'h0, rows[r][31:16]}, a);
         repeat (8) @(posedge pclk);
         apb(1'b0, rows[r][39:32], 32'h0, a);
         repeat (37) @(posedge pclk);
         apb(1'b0, rows[r][39:32], 32'h0, b);
         chk("count change", {16'h0, rows[r][15:0]}, {16'h0, b[15:0] - a[15:0]});
         apb(1'b1, rows[r][47:40], 32'h0, a);
      end
      // core latch is set by the underflow of the down row; wrap both cores upwards
      apb(1'b1, `GTU_OFS_CNT1, 32'h0000_fffe, a);
      apb(1'b1, `GTU_OFS_CNT4, 32'h0000_fffe, a);
      apb(1'b1, `GTU_OFS_CTRL1, 32'h0000_0801, a);
      apb(1'b1, `GTU_OFS_CTRL4, 32'h0000_0801, a);
      repeat (20) @(posedge pclk);
      apb(1'b0, `GTU_OFS_STAT, 32'h0, a);
      chk("latches after overflow", 32'h2, a);
      chk("pins after overflow", 32'h2, {30'h0, group_two_toggle_out_pin, core_toggle_out_pin});
      apb(1'b1, `GTU_OFS_CTRL1, 32'h0, a);
      apb(1'b1, `GTU_OFS_CNT1, 32'h0000_0001, a);
      apb(1'b1, `GTU_OFS_CTRL1, 32'h0000_0811, a);
      repeat (20) @(posedge pclk);
      apb(1'b0, `GTU_OFS_STAT, 32'h0, a);
      chk("latches after underflow", 32'h3, a);
      apb(1'b1, `GTU_OFS_CTRL1, 32'h0, a);
      apb(1'b1, `GTU_OFS_CTRL4, 32'h0, a);
      // event counting on the aux input pin
      apb(1'b1, `GTU_OFS_CNT0, 32'h0, a);
      apb(1'b1, `GTU_OFS_CTRL0, 32'h0000_0203, a);
      pulse(3'd0, 4'd5);
      apb(1'b0, `GTU_OFS_CNT0, 32'h0, a);
      chk("event count", 32'h5, a);
      // capture of the stopped core into aux b, which must not count
      apb(1'b1, `GTU_OFS_CNT1, 32'h0000_1234, a);
      apb(1'b1, `GTU_OFS_CTRL2, 32'h0000_020f, a);
      pulse(3'd2, 4'd1);
      repeat (20) @(posedge pclk);
      apb(1'b0, `GTU_OFS_CNT2, 32'h0, a);
      chk("captured core", 32'h0000_1234, a);
      // reload of the core from aux a on its pin edge
      apb(1'b1, `GTU_OFS_CNT0, 32'h0000_5555, a);
      apb(1'b1, `GTU_OFS_CTRL0, 32'h0000_020d, a);
      pulse(3'd0, 4'd1);
      apb(1'b0, `GTU_OFS_CNT1, 32'h0, a);
      chk("reloaded core", 32'h0000_5555, a);
      // capture reload register from the capture pin, then from the core input pin
      apb(1'b1, `GTU_OFS_CTRL4, 32'h0000_0200, a);
      for (int c = 0; c < 2; c++) begin
         apb(1'b1, `GTU_OFS_CNT3, 32'h0000_0abc + c, a);
         // the core input pin captures on both of its edges, so no clear there
         apb(1'b1, `GTU_OFS_CTRL3, (c == 0) ? 32'h0000_1000 : 32'h0000_2000, a);
         pulse((c == 0) ? 3'd5 : 3'd1, 4'd1);
         apb(1'b0, `GTU_OFS_CAPTURE_RELOAD_REG, 32'h0, a);
         chk("capture reload", 32'h0000_0abc + c, a);
         apb(1'b0, `GTU_OFS_CNT3, 32'h0, a);
         chk("cleared aux", (c == 0) ? 32'h0 : 32'h0000_0abd, a);
      end
      end_of_test();
   end
endmodule
